/* File: level_ctrl.sv */
// Automatic level control: registers, level detectors and gain engine
//
// What this block does
// - Bit 31 zero allows fast gain ramp-down above 87.5% full scale; one blocks it.
// - Bit 30 picks training measurement: zero absolute peak, one peak-to-peak.
// - Bit 29 picks noise gate measurement: zero peak-to-peak, one absolute peak.
// - Bit 28 switches level control on; cleared at reset.
// - Bits 27:25 gain ceiling, -6.75 dB plus 6 dB per code.
// - Bits 24:22 gain floor, -12 dB plus 6 dB per code.
// - Bit 21 makes gain changes wait for a zero crossing while control runs.
// - Bits 20:17 hold delay before gain rise in normal mode, two to the code in ms, codes above ten as ten.
// - Bits 16:13 target level, -28.5 dB plus 1.5 dB per code.
// - Bit 12 selects normal control or peak limiter mode.
// - Bits 11:8 decay time, doubling per step up to code ten, base 125us or 31us.
// - Bits 7:4 attack time, doubling per step up to code ten, base 500us or 125us.
// - Bit 3 switches the noise gate on in normal control mode.
// - Bits 2:0 noise threshold, -81 or -87 with boost, plus 6 dB per code.
// - Status word is read only with peak, swing, quiet and overload fields.
// - Status carries nine top bits of the absolute peak.
// - Status carries nine top bits of the peak-to-peak value.
// - Status bit 1 set while level is under the noise threshold.
// - Status bit 0 set while level is above 87.5% of full scale.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module level_ctrl
  import level_ctrl_pkg::*;
#(
  parameter int HOLD_BASE = HOLD_BASE_CYC,
  parameter int ATK_NORM = ATK_NORM_CYC,
  parameter int ATK_LIM = ATK_LIM_CYC,
  parameter int DEC_NORM = DEC_NORM_CYC,
  parameter int DEC_LIM = DEC_LIM_CYC,
  parameter int ZC_TIMEOUT = ZC_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire reg_req_type bus_req,
  output logic [31:0] rd_data,
  input wire logic signed [15:0] adc_sample,
  input wire logic adc_valid,
  input wire logic zero_cross_in,
  input wire logic mic_boost_on,
  input wire logic [5:0] manual_gain,
  output logic [5:0] gain_out,
  output logic gain_update
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_n_r;
  logic rst_sync_n_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_n_r <= 1'b1;
      rst_sync_n_r <= rst_meta_n_r;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  cfg_type cfg_r;
  status_type status_r;
  logic [31:0] rd_data_r;

  // Status address is decoded for reads only, so a write there is dropped
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      cfg_r <= cfg_type'(CFG_RESET);
    end else if (bus_req.wr && bus_req.addr == CFG_ADDR) begin
      cfg_r <= cfg_type'(bus_req.wdata);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      rd_data_r <= 32'h00000000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        CFG_ADDR: rd_data_r <= cfg_r;
        STS_ADDR: rd_data_r <= status_r;
        default: rd_data_r <= 32'h00000000;
      endcase
    end else begin
      rd_data_r <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // Level detectors
  // ----------------------------------------
  // Log estimate: 8 units per octave plus three mantissa bits
  function automatic logic signed [9:0] log_units(input logic [15:0] m);
    logic signed [9:0] r;
    logic [15:0] s;
    r = LOG_FLOOR_U;
    s = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        r = 10'((i - 15) * 8);
        s = 16'(m << (15 - i));
      end
    end
    return r + $signed({7'h00, s[14:12]});
  endfunction

  logic [15:0] mag;
  logic [15:0] peak_r;
  logic signed [15:0] max_r;
  logic signed [15:0] min_r;
  logic signed [16:0] diff;
  logic [15:0] swing;
  logic [15:0] swing_step;

  assign mag = adc_sample[15] ? 16'(-adc_sample) : adc_sample;
  assign diff = {max_r[15], max_r} - {min_r[15], min_r};
  assign swing = diff[16] ? 16'h0000 : diff[15:0];
  assign swing_step = 16'(swing >> (PEAK_DECAY_SH + 1)) + 16'h0001;

  // Peak loads on a larger sample and otherwise decays toward zero
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      peak_r <= 16'h0000;
    end else if (adc_valid) begin
      if (mag > peak_r) begin
        peak_r <= mag;
      end else if (peak_r != 16'h0000) begin
        peak_r <= peak_r - 16'(peak_r >> PEAK_DECAY_SH) - 16'h0001;
      end
    end
  end

  // Extremes close in on each other so the swing tracks a falling input
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      max_r <= 16'sh0000;
      min_r <= 16'sh0000;
    end else if (adc_valid) begin
      if (adc_sample > max_r) begin
        max_r <= adc_sample;
      end else if (swing != 16'h0000) begin
        max_r <= max_r - $signed(swing_step);
      end
      if (adc_sample < min_r) begin
        min_r <= adc_sample;
      end else if (swing != 16'h0000) begin
        min_r <= min_r + $signed(swing_step);
      end
    end
  end

  logic [5:0] gain_r;
  logic signed [9:0] train_lvl;
  logic signed [9:0] gate_lvl;
  logic signed [9:0] target_u;
  logic signed [9:0] gate_limit;
  logic clip_now;

  assign train_lvl = log_units(cfg_r.training_peak_source ? swing : peak_r);
  assign gate_lvl = log_units(cfg_r.gate_peak_source ? peak_r : swing);
  assign target_u = TGT_BASE_U + $signed({5'h00, cfg_r.target_level_code, 1'b0});
  // Threshold is input referred, so the present gain lifts it
  assign gate_limit = (mic_boost_on ? NG_BOOST_U : NG_BASE_U)
    + $signed({4'h0, cfg_r.noise_gate_threshold, 3'b000})
    + $signed({4'h0, gain_r}) + GAIN_OFS_U;
  assign clip_now = peak_r > CLIP_LEVEL;

  logic over_r;
  logic below_r;
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      status_r <= status_type'(STS_RESET);
      over_r <= 1'b0;
      below_r <= 1'b0;
    end else begin
      status_r.reserved <= 12'h000;
      status_r.abs_peak_reading <= peak_r[15:7];
      status_r.swing_reading <= swing[15:7];
      status_r.quiet_flag <= gate_lvl < gate_limit;
      status_r.overload_flag <= clip_now;
      over_r <= train_lvl > target_u;
      below_r <= train_lvl < target_u - HYST_U;
    end
  end

  // ----------------------------------------
  // Attack, decay and hold timers
  // ----------------------------------------
  logic en;
  logic lim;
  logic fast;
  assign en = cfg_r.level_ctrl_on;
  assign lim = cfg_r.limiter_select;
  assign fast = en && status_r.overload_flag && !cfg_r.fast_decrement_disable;

  logic [PRE_W-1:0] base_sel [3];
  logic [3:0] code_sel [3];
  logic [2:0] run_v;
  logic [2:0] tick_v;
  // Fast ramp-down uses the shortest attack entry of either table
  assign base_sel[0] = fast ? PRE_W'(ATK_LIM) : PRE_W'(lim ? ATK_LIM : ATK_NORM);
  assign code_sel[0] = fast ? 4'h0 : cfg_r.attack_time_code;
  assign base_sel[1] = PRE_W'(lim ? DEC_LIM : DEC_NORM);
  assign code_sel[1] = cfg_r.decay_time_code;
  assign base_sel[2] = PRE_W'(HOLD_BASE);
  assign code_sel[2] = cfg_r.hold_delay_code;
  assign run_v[0] = en;
  assign run_v[1] = en;
  assign run_v[2] = en && !lim && below_r;

  for (genvar t = 0; t < 3; t++) begin : g_timer
    logic [PRE_W-1:0] pre_r;
    logic [10:0] step_r;
    logic [10:0] last;
    logic tick_r;
    // Codes above ten are treated as ten
    assign last = 11'((11'h001 << (code_sel[t] > MAX_CODE ? MAX_CODE : code_sel[t])) - 11'h001);
    always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
        pre_r <= '0;
        step_r <= 11'h000;
        tick_r <= 1'b0;
      end else if (!run_v[t]) begin
        pre_r <= '0;
        step_r <= 11'h000;
        tick_r <= 1'b0;
      end else if (pre_r >= base_sel[t] - PRE_W'(1)) begin
        pre_r <= '0;
        tick_r <= step_r >= last;
        step_r <= (step_r >= last) ? 11'h000 : step_r + 11'h001;
      end else begin
        pre_r <= pre_r + PRE_W'(1);
        tick_r <= 1'b0;
      end
    end
    assign tick_v[t] = tick_r;
  end

  // Hold stays satisfied until the level climbs back into range
  logic hold_done_r;
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      hold_done_r <= 1'b0;
    end else if (!below_r || !en) begin
      hold_done_r <= 1'b0;
    end else if (tick_v[2]) begin
      hold_done_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Gain engine
  // ----------------------------------------
  logic en_d_r;
  logic [5:0] lim_ceil_r;
  logic [5:0] want_r;
  logic [5:0] ceil_idx;
  logic [5:0] floor_idx;
  logic may_rise;
  logic lim_ceil_q;
  assign ceil_idx = lim ? lim_ceil_r : {cfg_r.gain_ceiling, 3'b000} + CEIL_OFS;
  assign floor_idx = {cfg_r.gain_floor, 3'b000};
  assign may_rise = below_r && (lim || hold_done_r)
    && !(cfg_r.noise_gate_on && !lim && status_r.quiet_flag);

  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      en_d_r <= 1'b0;
      lim_ceil_r <= 6'h00;
    end else begin
      en_d_r <= en;
      if ((en && !en_d_r) || (en && lim && !lim_ceil_q)) begin
        lim_ceil_r <= gain_r;
      end
    end
  end

  // Limiter ceiling is taken when limiter operation begins
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      lim_ceil_q <= 1'b0;
    end else begin
      lim_ceil_q <= en && lim;
    end
  end

  // Ceiling wins over floor if software programs them crossed
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      want_r <= 6'h00;
    end else if (!en) begin
      want_r <= manual_gain;
    end else if (want_r > ceil_idx) begin
      want_r <= ceil_idx;
    end else if (want_r < floor_idx && floor_idx <= ceil_idx) begin
      // A crossed floor is ignored, otherwise the two clamps would fight
      want_r <= floor_idx;
    end else if (tick_v[0] && (over_r || fast) && want_r > floor_idx) begin
      want_r <= want_r - 6'h01;
    end else if (tick_v[1] && may_rise && want_r < ceil_idx) begin
      want_r <= want_r + 6'h01;
    end
  end

  // ----------------------------------------
  // Zero crossing gate
  // ----------------------------------------
  logic zc_meta_r;
  logic zc_sync_r;
  logic zc_prev_r;
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      zc_meta_r <= 1'b0;
      zc_sync_r <= 1'b0;
      zc_prev_r <= 1'b0;
    end else begin
      zc_meta_r <= zero_cross_in;
      zc_sync_r <= zc_meta_r;
      zc_prev_r <= zc_sync_r;
    end
  end

  gain_state_type gstate_r;
  logic [ZC_W-1:0] zc_cnt_r;
  logic gain_update_r;
  logic zc_hit;
  assign zc_hit = (zc_sync_r != zc_prev_r) || (zc_cnt_r >= ZC_W'(ZC_TIMEOUT - 1));

  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      gstate_r <= GAIN_IDLE;
      zc_cnt_r <= '0;
      gain_r <= 6'h00;
      gain_update_r <= 1'b0;
    end else begin
      gain_update_r <= 1'b0;
      case (gstate_r)
        GAIN_IDLE: begin
          zc_cnt_r <= '0;
          if (want_r != gain_r) begin
            if (en && cfg_r.zero_cross_gate_on) begin
              gstate_r <= GAIN_WAIT;
            end else begin
              gain_r <= want_r;
              gain_update_r <= 1'b1;
            end
          end
        end
        GAIN_WAIT: begin
          zc_cnt_r <= zc_cnt_r + ZC_W'(1);
          if (zc_hit || !en || !cfg_r.zero_cross_gate_on) begin
            gain_r <= want_r;
            gain_update_r <= want_r != gain_r;
            gstate_r <= GAIN_IDLE;
          end
        end
        default: begin
          gstate_r <= GAIN_IDLE;
        end
      endcase
    end
  end

  assign rd_data = rd_data_r;
  assign gain_out = gain_r;
  assign gain_update = gain_update_r;

endmodule // level_ctrl
`default_nettype wire

/* File: level_ctrl_pkg.sv */
// Constants and types shared by the level control register block
package level_ctrl_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] CFG_ADDR = 32'h400b0048;
  localparam logic [31:0] STS_ADDR = 32'h400b004c;
  localparam logic [31:0] CFG_RESET = 32'h0e016320;
  localparam logic [31:0] STS_RESET = 32'h00000000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int HOLD_BASE_US = 1000;
  localparam int ATK_NORM_US = 500;
  localparam int ATK_LIM_US = 125;
  localparam int DEC_NORM_US = 125;
  localparam int DEC_LIM_US = 31;
  localparam int ZC_TIMEOUT_US = 250000;
  localparam int HOLD_BASE_CYC = HOLD_BASE_US * CLK_MHZ;
  localparam int ATK_NORM_CYC = ATK_NORM_US * CLK_MHZ;
  localparam int ATK_LIM_CYC = ATK_LIM_US * CLK_MHZ;
  localparam int DEC_NORM_CYC = DEC_NORM_US * CLK_MHZ;
  localparam int DEC_LIM_CYC = DEC_LIM_US * CLK_MHZ;
  localparam int ZC_TIMEOUT_CYC = ZC_TIMEOUT_US * CLK_MHZ;
  localparam int PRE_W = 18;
  localparam int ZC_W = 26;
  localparam logic [3:0] MAX_CODE = 4'ha;
  // ----------------------------------------
  // Levels, in 0.75 dB units apart from the linear clip level and the decay shift
  // ----------------------------------------
  localparam logic [15:0] CLIP_LEVEL = 16'h7000;
  localparam int PEAK_DECAY_SH = 8;
  localparam logic signed [9:0] LOG_FLOOR_U = -10'sh080;
  localparam logic signed [9:0] TGT_BASE_U = -10'sh026;
  localparam logic signed [9:0] HYST_U = 10'sh002;
  localparam logic signed [9:0] NG_BASE_U = -10'sh06c;
  localparam logic signed [9:0] NG_BOOST_U = -10'sh074;
  localparam logic signed [9:0] GAIN_OFS_U = -10'sh010;
  localparam logic [5:0] CEIL_OFS = 6'h07;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic fast_decrement_disable;
    logic training_peak_source;
    logic gate_peak_source;
    logic level_ctrl_on;
    logic [2:0] gain_ceiling;
    logic [2:0] gain_floor;
    logic zero_cross_gate_on;
    logic [3:0] hold_delay_code;
    logic [3:0] target_level_code;
    logic limiter_select;
    logic [3:0] decay_time_code;
    logic [3:0] attack_time_code;
    logic noise_gate_on;
    logic [2:0] noise_gate_threshold;
  } cfg_type;
  typedef struct packed {
    logic [11:0] reserved;
    logic [8:0] abs_peak_reading;
    logic [8:0] swing_reading;
    logic quiet_flag;
    logic overload_flag;
  } status_type;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
  typedef enum logic [1:0] {
    GAIN_IDLE = 2'b01,
    GAIN_WAIT = 2'b10
  } gain_state_type;
endpackage

/* File: level_ctrl_monitor.sv */
// Port checks for the level control block
`timescale 1ns/10ps
`default_nettype none
module level_ctrl_monitor
  import level_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire reg_req_type bus_req,
  input wire logic [31:0] rd_data,
  input wire logic signed [15:0] adc_sample,
  input wire logic adc_valid,
  input wire logic zero_cross_in,
  input wire logic mic_boost_on,
  input wire logic [5:0] manual_gain,
  input wire logic [5:0] gain_out,
  input wire logic gain_update
);
  // Shadow of the config word, so the gain checks know the limits in force
  logic [31:0] cfg_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
    end else if (bus_req.wr && bus_req.addr == CFG_ADDR) begin
      cfg_r <= bus_req.wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  property p_rd_idle;
    !$past(bus_req.rd) |-> rd_data == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped;
    bus_req.rd && bus_req.addr != CFG_ADDR && bus_req.addr != STS_ADDR |=> rd_data == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reserved;
    bus_req.rd && bus_req.addr == STS_ADDR |=> rd_data[31:20] == 12'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits set");
  property p_readback;
    bus_req.wr && bus_req.addr == CFG_ADDR ##1 bus_req.rd && bus_req.addr == CFG_ADDR
      |=> rd_data == $past(bus_req.wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("config readback differs");
  property p_sts_write;
    (!adc_valid && !gain_update)[*3] ##0 (bus_req.rd && bus_req.addr == STS_ADDR)
      ##1 (!adc_valid && !gain_update && bus_req.wr && bus_req.addr == STS_ADDR)
      ##1 (!adc_valid && !gain_update && bus_req.rd && bus_req.addr == STS_ADDR)
      |=> rd_data == $past(rd_data, 2);
  endproperty
  a_sts_write: assert property (p_sts_write) else $error("status write had effect");
  // ----------------------------------------
  // Detectors and gain
  // ----------------------------------------
  property p_peak;
    adc_valid && adc_sample == 16'sh7fff ##1 (!adc_valid)[*2]
      ##1 (!adc_valid && bus_req.rd && bus_req.addr == STS_ADDR) |=> rd_data[19:11] >= 9'h0ff;
  endproperty
  a_peak: assert property (p_peak) else $error("peak field too small");
  property p_overload;
    adc_valid && adc_sample > 16'sh7000 ##1 (!adc_valid)[*2]
      ##1 (!adc_valid && bus_req.rd && bus_req.addr == STS_ADDR) |=> rd_data[0];
  endproperty
  a_overload: assert property (p_overload) else $error("overload flag missing");
  property p_manual;
    (!cfg_r[28] && $stable(manual_gain))[*5] |-> gain_out == manual_gain;
  endproperty
  a_manual: assert property (p_manual) else $error("gain not manual while off");
  property p_ceiling;
    gain_update && cfg_r[28] && !cfg_r[12] && !cfg_r[21] && $past(cfg_r, 3) == cfg_r
      |-> gain_out <= {cfg_r[27:25], 3'b111};
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("gain above ceiling");
  property p_floor;
    gain_update && cfg_r[28] && !cfg_r[12] && !cfg_r[21] && cfg_r[24:22] <= cfg_r[27:25]
      && $past(cfg_r, 3) == cfg_r |-> gain_out >= {cfg_r[24:22], 3'b000};
  endproperty
  a_floor: assert property (p_floor) else $error("gain below floor");
endmodule // level_ctrl_monitor
bind level_ctrl level_ctrl_monitor mon_u (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req),
  .rd_data(rd_data), .adc_sample(adc_sample), .adc_valid(adc_valid),
  .zero_cross_in(zero_cross_in), .mic_boost_on(mic_boost_on), .manual_gain(manual_gain),
  .gain_out(gain_out), .gain_update(gain_update));
`default_nettype wire

/* File: level_ctrl_bench.sv */
// Self-checking bench for the level control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module level_ctrl_bench
  import level_ctrl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  reg_req_type bus_req = '0;
  logic [31:0] rd_data;
  logic signed [15:0] adc_sample = 16'sh0;
  logic adc_valid = 1'b0;
  logic zero_cross_in = 1'b0;
  logic mic_boost_on = 1'b0;
  logic [5:0] manual_gain = 6'h0;
  logic [5:0] gain_out;
  logic gain_update;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'hf64029ec;
  logic [31:0] r, q, d, a;
  logic [2:0] c, f;
  always #2 clk_sys = ~clk_sys;
  // Short timer bases keep the gain walks to a few thousand cycles
  level_ctrl #(.HOLD_BASE(20), .ATK_NORM(16), .ATK_LIM(8), .DEC_NORM(8),
    .ZC_TIMEOUT(50)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req),
    .rd_data(rd_data), .adc_sample(adc_sample), .adc_valid(adc_valid),
    .zero_cross_in(zero_cross_in), .mic_boost_on(mic_boost_on), .manual_gain(manual_gain),
    .gain_out(gain_out), .gain_update(gain_update));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Entered just after an edge; leaves 1 ns after the edge that took the request
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    bus_req <= '{addr: ad, wdata: wd, wr: w, rd: !w};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    #1;
    q = rd_data;
  endtask
  task automatic rchk(input logic [31:0] ad, input logic [31:0] m, input logic [31:0] e,
      input string nm);
    bus(1'b0, ad, 32'h0);
    `CHK(nm, e, q & m)
  endtask
  task automatic smp(input logic [15:0] v, input int n);
    repeat (n) begin
      r = xs();
      adc_sample <= v;
      adc_valid <= 1'b1;
      zero_cross_in <= r[0];
      @(posedge clk_sys);
    end
    adc_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rchk(CFG_ADDR, '1, CFG_RESET, "config reset");
    rchk(STS_ADDR, 32'hfffffffd, 32'h0, "status reset");
    for (int i = 0; i < 40; i++) begin
      r = xs();
      adc_sample <= r[31:16];
      adc_valid <= r[2];
      mic_boost_on <= r[3];
      manual_gain <= r[9:4];
      d = (i == 0) ? '1 : (i == 1) ? 32'h0 : xs();
      a = CFG_ADDR + 32'h8 + {27'h0, r[7:5], 2'b00};
      bus(1'b1, CFG_ADDR, d);
      rchk(CFG_ADDR, '1, d, "config");
      bus(1'b1, a, ~d);
      rchk(a, '1, 32'h0, "unmapped");
      rchk(CFG_ADDR, '1, d, "config kept");
    end
    bus(1'b1, CFG_ADDR, CFG_RESET);
    manual_gain <= 6'h0;
    mic_boost_on <= 1'b0;
    smp(16'h0, 3000);
    rchk(STS_ADDR, '1, 32'h2, "quiet status");
    bus(1'b1, STS_ADDR, '1);
    rchk(STS_ADDR, '1, 32'h2, "status after write");
    smp(16'h7fff, 1);
    rchk(STS_ADDR, 32'h000ff801, 32'h0007f801, "peak and overload");
    smp(16'h8000, 1);
    bus(1'b0, STS_ADDR, 32'h0);
    `CHK("swing", 1'b1, q[10:2] >= 9'h1f0)
    for (int i = 0; i < 8; i++) begin
      r = xs();
      manual_gain <= (i == 0) ? 6'h3f : r[5:0];
      repeat (6) @(posedge clk_sys);
      #1;
      `CHK("manual gain", manual_gain, gain_out)
    end
    for (int i = 0; i < 3; i++) begin
      c = 3'(7 - 3 * i);
      f = 3'(i);
      @(posedge clk_sys);
      bus(1'b1, CFG_ADDR, {i == 2, 3'b001, c, f, i == 1, 21'h0});
      smp(16'h7fff, 2000);
      `CHK("gain low", (f <= c) ? {f, 3'b000} : {c, 3'b111}, gain_out)
      smp(16'h0001, 6000);
      `CHK("gain high", {c, 3'b111}, gain_out)
    end
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end
endmodule // level_ctrl_bench
`default_nettype wire
